// ### verilog/frc_top.sv
// frequency reference combiner with avalon register slave
// Notes on behaviour
// - setting picks motor set; terminal overrides
// - units 0: reference is main X
// - units 1: arithmetic relation from tens digit
// - units 2: terminal picks Y else X
// - units 3: terminal picks result else X
// - units 4: terminal picks result else Y
// - tens: sum, difference, minimum, maximum
// - offset added to arithmetic result
// - aux range percent of max or X
// - analog/pulse aux full scale equals range
// - digital aux: preset ignored, updown on main
// - binding digits: keypad, terminal, comm channels
// - bound source overrides all other sources
// - mode 0: fan on running or hot
// - mode 1: fan always on
// - reversal holds zero for dwell time
// - load speed from output or set frequency
// - decimals setting fixes display decimal places
// - load type read only, 1 or 2
// - display selections 16-bit, default 401F
// - analog, pulse full scale is maximum
`timescale 1ns/1ps
`default_nettype none
module frc_top
  import frc_pkg::*;
#(
  parameter int          FW              = 16,
  parameter int          DWELL_STEP_CYC  = FRC_DWELL_STEP_CYC,
  parameter logic [1:0]  LOAD_TYPE       = 2'h1
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic [7:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic      [31:0]   avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic [FW-1:0] max_freq,
  input  wire logic [FW-1:0] main_freq_x,
  input  wire logic [FW-1:0] aux_raw_y,
  input  wire logic          aux_is_digital,
  input  wire logic [FW-1:0] updown_adjust,
  input  wire logic [FW-1:0] source_freq_0,
  input  wire logic [FW-1:0] source_freq_1,
  input  wire logic [FW-1:0] source_freq_2,
  input  wire logic [FW-1:0] source_freq_3,
  input  wire logic [FW-1:0] source_freq_4,
  input  wire logic [FW-1:0] source_freq_5,
  input  wire logic [FW-1:0] source_freq_6,
  input  wire logic [FW-1:0] source_freq_7,
  input  wire logic [FW-1:0] source_freq_8,
  input  wire logic [1:0]    cmd_channel,
  input  wire logic          switch_term_pin,
  input  wire logic          motor_term_valid_pin,
  input  wire logic          motor_term_sel_pin,
  input  wire logic          run_pin,
  input  wire logic          reverse_pin,
  input  wire logic [15:0]   heatsink_temp,
  input  wire logic [FW-1:0] output_freq,
  output logic      [FW-1:0] freq_reference,
  output logic               motor_set_two,
  output logic               fan_on,
  output logic               zero_hold,
  output logic               dir_reverse,
  output logic      [FW-1:0] load_speed,
  output logic      [1:0]    load_speed_places,
  output logic      [1:0]    monitor_places
);
  // settings
  logic          motor_set_select_r;
  logic          aux_range_reference_select_r;
  logic [7:0]    aux_range_percent_r;
  logic [7:0]    source_combination_mode_r;
  logic [FW-1:0] combination_offset_freq_r;
  logic [11:0]   command_source_binding_r;
  logic          fan_control_mode_r;
  logic [15:0]   reversal_dwell_time_r;
  logic [15:0]   run_display_select_a_r;
  logic [15:0]   run_display_select_b_r;
  logic [15:0]   stop_display_select_r;
  logic [15:0]   load_speed_factor_r;
  logic [7:0]    load_speed_decimals_r;

  // pin synchronisers, stage one feeds stage two only
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {switch_term_pin, motor_term_valid_pin, motor_term_sel_pin,
                   run_pin, reverse_pin};
      pin_s2_r <= pin_s1_r;
    end
  end
  logic switch_term;
  logic term_valid;
  logic term_sel;
  logic running;
  logic rev_req;
  assign {switch_term, term_valid, term_sel, running, rev_req} = pin_s2_r;

  // byte-lane merge shared by all writable registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [FW-1:0] clampsub(input logic [FW-1:0] a, input logic [FW-1:0] b);
    return (a > b) ? a - b : '0;
  endfunction

  // writes land at once; a read waits one cycle so registered data stand when it is taken
  logic        rd_wait_r;
  logic [31:0] cur;
  logic [31:0] nw;
  always_ff @(posedge clk) begin
    if (!rstn) rd_wait_r <= 1'b0;
    else rd_wait_r <= avs_read && !rd_wait_r;
  end
  assign avs_waitrequest = avs_read && !rd_wait_r;

  // current value of the addressed writable register, for lane merging
  always_comb begin
    case (avs_address)
      FRC_OFS_MOTOR_SEL:   cur = {31'h0, motor_set_select_r};
      FRC_OFS_AUX_RANGE:   cur = {23'h0, aux_range_reference_select_r, aux_range_percent_r};
      FRC_OFS_COMB_MODE:   cur = {24'h0, source_combination_mode_r};
      FRC_OFS_OFFSET_FREQ: cur = 32'(combination_offset_freq_r);
      FRC_OFS_BINDING:     cur = {20'h0, command_source_binding_r};
      FRC_OFS_FAN_MODE:    cur = {31'h0, fan_control_mode_r};
      FRC_OFS_DWELL:       cur = {16'h0, reversal_dwell_time_r};
      FRC_OFS_DISP_A:      cur = {16'h0, run_display_select_a_r};
      FRC_OFS_DISP_B:      cur = {16'h0, run_display_select_b_r};
      FRC_OFS_DISP_STOP:   cur = {16'h0, stop_display_select_r};
      FRC_OFS_LOAD_FACTOR: cur = {16'h0, load_speed_factor_r};
      FRC_OFS_DECIMALS:    cur = {24'h0, load_speed_decimals_r};
      default:             cur = 32'h0;
    endcase
    nw = merge(cur, avs_writedata, avs_byteenable);
  end

  // register writes; out-of-range values are refused and the old value kept
  always_ff @(posedge clk) begin
    if (!rstn) begin
      motor_set_select_r           <= 1'b0;
      aux_range_reference_select_r <= 1'b0;
      aux_range_percent_r          <= 8'h00;
      source_combination_mode_r    <= 8'h00;
      combination_offset_freq_r    <= '0;
      command_source_binding_r     <= 12'h000;
      fan_control_mode_r           <= 1'b0;
      reversal_dwell_time_r        <= 16'h0000;
      run_display_select_a_r       <= FRC_RST_DISP;
      run_display_select_b_r       <= FRC_RST_DISP;
      stop_display_select_r        <= FRC_RST_DISP;
      load_speed_factor_r          <= FRC_RST_LOAD_FACT;
      load_speed_decimals_r        <= FRC_RST_DECIMALS;
    end else if (avs_write) begin
      case (avs_address)
        FRC_OFS_MOTOR_SEL:   motor_set_select_r <= nw[0];
        FRC_OFS_AUX_RANGE: begin
          aux_range_reference_select_r <= nw[8];
          if (nw[7:0] <= FRC_AUX_PCT_MAX) aux_range_percent_r <= nw[7:0];
        end
        FRC_OFS_COMB_MODE: begin
          if (nw[3:0] <= 4'h4 && nw[7:4] <= 4'h3) source_combination_mode_r <= nw[7:0];
        end
        FRC_OFS_OFFSET_FREQ: combination_offset_freq_r <= nw[FW-1:0];
        FRC_OFS_BINDING: begin
          if (nw[3:0] <= 4'h9 && nw[7:4] <= 4'h9 && nw[11:8] <= 4'h9)
            command_source_binding_r <= nw[11:0];
        end
        FRC_OFS_FAN_MODE:    fan_control_mode_r <= nw[0];
        FRC_OFS_DWELL: begin
          if (nw[15:0] <= FRC_DWELL_MAX) reversal_dwell_time_r <= nw[15:0];
        end
        FRC_OFS_DISP_A:      run_display_select_a_r <= nw[15:0];
        FRC_OFS_DISP_B:      run_display_select_b_r <= nw[15:0];
        FRC_OFS_DISP_STOP:   stop_display_select_r  <= nw[15:0];
        FRC_OFS_LOAD_FACTOR: begin
          if (nw[15:0] >= FRC_LOAD_FACT_MIN && nw[15:0] <= FRC_LOAD_FACT_MAX)
            load_speed_factor_r <= nw[15:0];
        end
        FRC_OFS_DECIMALS: begin
          if (nw[3:0] <= 4'h3 && nw[7:4] <= 4'h2) load_speed_decimals_r <= nw[7:0];
        end
        default: ;
      endcase
    end
  end

  // motor parameter set: terminal wins when it is asserted valid
  always_ff @(posedge clk) begin
    if (!rstn) begin
      motor_set_two <= 1'b0;
    end else begin
      motor_set_two <= term_valid ? term_sel : motor_set_select_r;
    end
  end

  // auxiliary scaling: full-scale input maps to range percent of the base
  logic [FW-1:0] aux_base;
  logic [FW-1:0] aux_range;
  logic [FW-1:0] aux_scaled;
  logic [FW-1:0] aux_y;
  assign aux_base = aux_range_reference_select_r ? main_freq_x : max_freq;
  frc_scale #(.AW(FW), .BW(8), .DIV(100)) u_range (
    .clk  (clk),
    .rstn (rstn),
    .a    (aux_base),
    .b    (aux_range_percent_r),
    .q_r  (aux_range)
  );
  // raw aux is a full-scale fraction in max_freq units; rescale to range
  always_comb begin
    logic [2*FW-1:0] p;
    p = aux_raw_y * aux_range;
    if (max_freq == '0) begin
      aux_scaled = '0;
    end else begin
      aux_scaled = FW'(p / (2*FW)'(max_freq));
    end
  end
  // digital aux ignores preset: only the up/down adjustment is added
  assign aux_y = aux_is_digital ? updown_adjust : aux_scaled;

  // arithmetic relation from the tens digit; main x is already max-scaled
  logic [3:0]    unit_d;
  logic [3:0]    tens_d;
  logic [FW:0]   arith_sum;
  logic [FW-1:0] arith;
  logic [FW-1:0] arith_off;
  logic [FW:0]   off_sum;
  assign unit_d = source_combination_mode_r[FRC_MODE_UNIT_LSB +: 4];
  assign tens_d = source_combination_mode_r[FRC_MODE_TENS_LSB +: 4];
  always_comb begin
    arith_sum = {1'b0, main_freq_x} + {1'b0, aux_y};
    case (tens_d)
      4'h0: arith = arith_sum[FW] ? '1 : arith_sum[FW-1:0];
      4'h1: arith = clampsub(main_freq_x, aux_y);
      4'h2: arith = (main_freq_x < aux_y) ? main_freq_x : aux_y;
      4'h3: arith = (main_freq_x > aux_y) ? main_freq_x : aux_y;
      default: arith = main_freq_x;
    endcase
    off_sum   = {1'b0, arith} + {1'b0, combination_offset_freq_r};
    arith_off = off_sum[FW] ? '1 : off_sum[FW-1:0];
  end

  // combination select by the units digit
  logic [FW-1:0] combined;
  always_comb begin
    case (unit_d)
      4'h0: combined = main_freq_x;
      4'h1: combined = arith_off;
      4'h2: combined = switch_term ? aux_y : main_freq_x;
      4'h3: combined = switch_term ? arith_off : main_freq_x;
      4'h4: combined = switch_term ? arith_off : aux_y;
      default: combined = main_freq_x;
    endcase
  end

  // command channel binding: 0 keypad, 1 terminal, 2 communication
  logic [3:0]    bind_code;
  logic [FW-1:0] bound_freq;
  logic [FW-1:0] set_freq;
  always_comb begin
    case (cmd_channel)
      2'd0:    bind_code = command_source_binding_r[3:0];
      2'd1:    bind_code = command_source_binding_r[7:4];
      2'd2:    bind_code = command_source_binding_r[11:8];
      default: bind_code = 4'h0;
    endcase
    case (frc_src_t'(bind_code))
      FRC_SRC_DIGITAL: bound_freq = source_freq_0;
      FRC_SRC_AI1:     bound_freq = source_freq_1;
      FRC_SRC_AI2:     bound_freq = source_freq_2;
      FRC_SRC_AI3:     bound_freq = source_freq_3;
      FRC_SRC_PULSE:   bound_freq = source_freq_4;
      FRC_SRC_MULTI:   bound_freq = source_freq_5;
      FRC_SRC_SEQ:     bound_freq = source_freq_6;
      FRC_SRC_PID:     bound_freq = source_freq_7;
      FRC_SRC_COMM:    bound_freq = source_freq_8;
      default:         bound_freq = '0;
    endcase
    // a bound source shuts out every other source while its channel rules
    set_freq = (bind_code != 4'h0) ? bound_freq : combined;
  end

  // reversal dwell: zero output for dwell steps of 0.1 s each
  frc_dir_state_t dir_st_r;
  logic [31:0]    step_cnt_r;
  logic [15:0]    dwell_cnt_r;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dir_st_r    <= FRC_DIR_RUN;
      dir_reverse <= 1'b0;
      step_cnt_r  <= '0;
      dwell_cnt_r <= '0;
    end else begin
      case (dir_st_r)
        FRC_DIR_RUN: begin
          if (rev_req != dir_reverse) begin
            if (reversal_dwell_time_r == 16'h0000) begin
              dir_reverse <= rev_req;
            end else begin
              dir_st_r    <= FRC_DIR_HOLD;
              dwell_cnt_r <= reversal_dwell_time_r;
              step_cnt_r  <= '0;
            end
          end
        end
        FRC_DIR_HOLD: begin
          if (step_cnt_r == 32'(DWELL_STEP_CYC - 1)) begin
            step_cnt_r <= '0;
            if (dwell_cnt_r == 16'h0001) begin
              dir_st_r    <= FRC_DIR_RUN;
              dir_reverse <= rev_req;
            end
            dwell_cnt_r <= dwell_cnt_r - 16'h0001;
          end else begin
            step_cnt_r <= step_cnt_r + 32'h1;
          end
        end
        default: dir_st_r <= FRC_DIR_RUN;
      endcase
    end
  end
  assign zero_hold = (dir_st_r == FRC_DIR_HOLD);

  // reference output register, forced to zero during the dwell
  always_ff @(posedge clk) begin
    if (!rstn) begin
      freq_reference <= '0;
    end else begin
      freq_reference <= zero_hold ? '0 : set_freq;
    end
  end

  // fan control
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fan_on <= 1'b0;
    end else if (fan_control_mode_r) begin
      fan_on <= 1'b1;
    end else begin
      fan_on <= running || (heatsink_temp > FRC_FAN_TEMP_LIMIT);
    end
  end

  // load speed: output frequency while running, set frequency when stopped
  logic [FW-1:0] speed_src;
  assign speed_src = running ? output_freq : freq_reference;
  frc_scale #(.AW(FW), .BW(16), .DIV(10000)) u_speed (
    .clk  (clk),
    .rstn (rstn),
    .a    (speed_src),
    .b    (load_speed_factor_r),
    .q_r  (load_speed)
  );
  always_ff @(posedge clk) begin
    if (!rstn) begin
      load_speed_places <= 2'h0;
      monitor_places    <= 2'h0;
    end else begin
      load_speed_places <= load_speed_decimals_r[1:0];
      monitor_places    <= load_speed_decimals_r[5:4];
    end
  end

  // read data; load type is read only, writes to it are dropped
  always_ff @(posedge clk) begin
    if (!rstn) begin
      avs_readdata <= 32'h0;
    end else if (avs_read) begin
      case (avs_address)
        FRC_OFS_LOAD_TYPE:  avs_readdata <= {30'h0, LOAD_TYPE};
        FRC_OFS_STATUS:     avs_readdata <= {27'h0, dir_reverse, zero_hold, fan_on,
                                             switch_term, motor_set_two};
        FRC_OFS_REF_OUT:    avs_readdata <= 32'(freq_reference);
        FRC_OFS_LOAD_SPEED: avs_readdata <= 32'(load_speed);
        default:            avs_readdata <= cur;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### verilog/frc_pkg.sv
// constants for the frequency reference combiner
package frc_pkg;
  // register word offsets (byte addresses)
  localparam logic [7:0] FRC_OFS_MOTOR_SEL   = 8'h00;
  localparam logic [7:0] FRC_OFS_AUX_RANGE   = 8'h04;
  localparam logic [7:0] FRC_OFS_COMB_MODE   = 8'h08;
  localparam logic [7:0] FRC_OFS_OFFSET_FREQ = 8'h0C;
  localparam logic [7:0] FRC_OFS_BINDING     = 8'h10;
  localparam logic [7:0] FRC_OFS_FAN_MODE    = 8'h14;
  localparam logic [7:0] FRC_OFS_DWELL       = 8'h18;
  localparam logic [7:0] FRC_OFS_DISP_A      = 8'h1C;
  localparam logic [7:0] FRC_OFS_DISP_B      = 8'h20;
  localparam logic [7:0] FRC_OFS_DISP_STOP   = 8'h24;
  localparam logic [7:0] FRC_OFS_LOAD_FACTOR = 8'h28;
  localparam logic [7:0] FRC_OFS_DECIMALS    = 8'h2C;
  localparam logic [7:0] FRC_OFS_LOAD_TYPE   = 8'h30;
  localparam logic [7:0] FRC_OFS_STATUS      = 8'h34;
  localparam logic [7:0] FRC_OFS_REF_OUT     = 8'h38;
  localparam logic [7:0] FRC_OFS_LOAD_SPEED  = 8'h3C;
  // reset values
  localparam logic [15:0] FRC_RST_DISP       = 16'h401F;
  localparam logic [15:0] FRC_RST_LOAD_FACT  = 16'h7530; // 3.0000 in 0.0001 steps
  localparam logic [7:0]  FRC_RST_DECIMALS   = 8'h15;    // 21
  localparam logic [15:0] FRC_LOAD_FACT_MIN  = 16'h0001;
  localparam logic [15:0] FRC_LOAD_FACT_MAX  = 16'hFDE8; // 6.5000
  localparam logic [7:0]  FRC_AUX_PCT_MAX    = 8'h96;    // 150 percent
  localparam logic [15:0] FRC_DWELL_MAX      = 16'h7530; // 3000.0 s in 0.1 s
  localparam logic [15:0] FRC_FAN_TEMP_LIMIT = 16'h0028; // 40 degrees
  // fields
  localparam int FRC_MODE_UNIT_LSB = 0;
  localparam int FRC_MODE_TENS_LSB = 4;
  // timing: one dwell step of 0.1 s
  localparam int FRC_CLK_HZ        = 125_000_000;
  localparam int FRC_DWELL_STEP_MS = 100;
  localparam int FRC_DWELL_STEP_CYC = FRC_CLK_HZ / 1000 * FRC_DWELL_STEP_MS;

  typedef enum logic [1:0] {
    FRC_DIR_RUN  = 2'b00,
    FRC_DIR_HOLD = 2'b01
  } frc_dir_state_t;

  // fixed frequency source codes used by the binding setting
  typedef enum logic [3:0] {
    FRC_SRC_NONE = 4'h0, FRC_SRC_DIGITAL = 4'h1, FRC_SRC_AI1 = 4'h2,
    FRC_SRC_AI2 = 4'h3, FRC_SRC_AI3 = 4'h4, FRC_SRC_PULSE = 4'h5,
    FRC_SRC_MULTI = 4'h6, FRC_SRC_SEQ = 4'h7, FRC_SRC_PID = 4'h8,
    FRC_SRC_COMM = 4'h9
  } frc_src_t;
endpackage

// ### verilog/frc_scale.sv
// registered fractional scaler: out = a * b / div
`timescale 1ns/1ps
`default_nettype none
module frc_scale #(
  parameter int AW = 16,
  parameter int BW = 16,
  parameter int DIV = 100
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic [AW-1:0] a,
  input  wire logic [BW-1:0] b,
  output logic      [AW-1:0] q_r
);
  logic [AW+BW-1:0] prod;
  logic [AW+BW-1:0] quo;
  // quotient saturates so large factors never wrap the result
  always_comb begin
    prod = a * b;
    quo  = prod / (AW+BW)'(DIV);
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q_r <= '0;
    end else if (|quo[AW+BW-1:AW]) begin
      q_r <= '1;
    end else begin
      q_r <= quo[AW-1:0];
    end
  end
endmodule
`default_nettype wire

// ### verification/frc_top_sva.sv
// port-level assertion checker for the frequency reference combiner
`timescale 1ns/1ps
`default_nettype none
module frc_top_sva
  import frc_pkg::*;
#(
  parameter int         FW             = 16,
  parameter int         DWELL_STEP_CYC = 4,
  parameter logic [1:0] LOAD_TYPE      = 2'h1
) (
  input wire logic          clk,
  input wire logic          rstn,
  input wire logic [7:0]    avs_address,
  input wire logic          avs_read,
  input wire logic          avs_write,
  input wire logic [31:0]   avs_writedata,
  input wire logic [31:0]   avs_readdata,
  input wire logic          avs_waitrequest,
  input wire logic          run_pin,
  input wire logic          motor_term_valid_pin,
  input wire logic          motor_term_sel_pin,
  input wire logic [15:0]   heatsink_temp,
  input wire logic [FW-1:0] freq_reference,
  input wire logic          motor_set_two,
  input wire logic          fan_on,
  input wire logic          zero_hold,
  input wire logic [1:0]    load_speed_places,
  input wire logic [1:0]    monitor_places
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic        fan_r;
  logic [15:0] dwell_r;
  logic [7:0]  dec_r;
  // shadow of settings; refused values are skipped just as the slave does
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fan_r <= 1'b0;
      dwell_r <= 16'h0;
      dec_r <= FRC_RST_DECIMALS;
    end else if (avs_write) begin
      if (avs_address == FRC_OFS_FAN_MODE) fan_r <= avs_writedata[0];
      if (avs_address == FRC_OFS_DWELL && avs_writedata[15:0] <= FRC_DWELL_MAX)
        dwell_r <= avs_writedata[15:0];
      if (avs_address == FRC_OFS_DECIMALS && avs_writedata[3:0] <= 4'h3
          && avs_writedata[7:4] <= 4'h2) dec_r <= avs_writedata[7:0];
    end
  end
  // pins pass a two-stage sync, so pin relations allow five cycles
  sequence s_two_sel; (motor_term_valid_pin && motor_term_sel_pin) [*5]; endsequence
  sequence s_hold; zero_hold [*4]; endsequence
  property p_no_wait; avs_write |-> avs_waitrequest == 1'b0; endproperty
  property p_unmapped; avs_read && avs_address == 8'hFC |=> avs_readdata == 32'h0; endproperty
  property p_load_type;
    avs_read && avs_address == FRC_OFS_LOAD_TYPE |=> avs_readdata == {30'h0, LOAD_TYPE};
  endproperty
  property p_motor; s_two_sel |-> motor_set_two; endproperty
  property p_fan_always; fan_r [*3] |-> fan_on; endproperty
  property p_fan_run; (!fan_r && run_pin) [*5] |-> fan_on; endproperty
  property p_fan_hot; (!fan_r && heatsink_temp > FRC_FAN_TEMP_LIMIT) [*5] |-> fan_on; endproperty
  property p_fan_idle;
    (!fan_r && !run_pin && heatsink_temp <= FRC_FAN_TEMP_LIMIT) [*5] |-> !fan_on;
  endproperty
  property p_zero; zero_hold && $past(zero_hold) |-> freq_reference == '0; endproperty
  property p_dwell; $rose(zero_hold) && dwell_r != 16'h0 |-> s_hold; endproperty
  property p_places;
    $past(rstn, 3) && dec_r == $past(dec_r, 3)
      |-> load_speed_places == dec_r[1:0] && monitor_places == dec_r[5:4];
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("waitrequest raised on write");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_load_type: assert property (p_load_type) else $error("load type wrong");
  a_motor: assert property (p_motor) else $error("terminal did not pick set two");
  a_fan_always: assert property (p_fan_always) else $error("fan off in mode 1");
  a_fan_run: assert property (p_fan_run) else $error("fan off while running");
  a_fan_hot: assert property (p_fan_hot) else $error("fan off while hot");
  a_fan_idle: assert property (p_fan_idle) else $error("fan on idle and cool");
  a_zero: assert property (p_zero) else $error("reference not zero in dwell");
  a_dwell: assert property (p_dwell) else $error("dwell hold too short");
  a_places: assert property (p_places) else $error("decimal places wrong");
endmodule
bind frc_top frc_top_sva #(.FW(FW), .DWELL_STEP_CYC(DWELL_STEP_CYC), .LOAD_TYPE(LOAD_TYPE)) u_sva (
  .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .run_pin(run_pin),
  .motor_term_valid_pin(motor_term_valid_pin), .motor_term_sel_pin(motor_term_sel_pin),
  .heatsink_temp(heatsink_temp), .freq_reference(freq_reference),
  .motor_set_two(motor_set_two), .fan_on(fan_on), .zero_hold(zero_hold),
  .load_speed_places(load_speed_places), .monitor_places(monitor_places));
`default_nettype wire

// ### verification/frc_term_model.sv
// terminal panel model: puts the requested contact states on the pins
`timescale 1ns/1ps
`default_nettype none
module frc_term_model (
  input  wire logic       clk,
  input  wire logic [4:0] req,
  output logic            switch_term_pin,
  output logic            motor_term_valid_pin,
  output logic            motor_term_sel_pin,
  output logic            run_pin,
  output logic            reverse_pin
);
  // contacts move just after an edge; the block resyncs them anyway
  always_ff @(posedge clk) begin
    {reverse_pin, run_pin, motor_term_sel_pin, motor_term_valid_pin, switch_term_pin} <= req;
  end
endmodule
`default_nettype wire

// ### verification/tb_frc_top.sv
// self-checking bench for the frequency reference combiner
`timescale 1ns/1ps
`default_nettype none
module tb_frc_top;
  import frc_pkg::*;
  localparam int STEP = 4;
  // rows: mode, switch, raw aux, expected reference
  localparam logic [47:0] TAB [12] = '{48'h00_01_03E8_0BB8, 48'h01_00_03E8_0FD2,
    48'h11_00_03E8_0802, 48'h21_00_03E8_041A, 48'h31_00_03E8_0BEA, 48'h11_00_0FA0_0032,
    48'h02_01_03E8_03E8, 48'h02_00_03E8_0BB8, 48'h03_01_03E8_0FD2, 48'h03_00_03E8_0BB8,
    48'h14_01_03E8_0802, 48'h14_00_03E8_03E8};
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        wreq;
  logic [15:0] yraw = 16'h03E8;
  logic        aux_dig = 1'b0;
  logic [15:0] src [9];
  logic [1:0]  cmd = 2'h3;
  logic [4:0]  term = 5'h00;
  logic [15:0] temp = 16'h0000;
  logic [15:0] ofreq = 16'h0FA0;
  logic [15:0] fref, lspd;
  logic        m2, fan, zh, drev, sw, mv, ms, runp, revp;
  logic [1:0]  lpl, mpl;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          n;
  always #4 clk = ~clk;
  frc_term_model u_frc_term_model (.clk(clk), .req(term), .switch_term_pin(sw),
    .motor_term_valid_pin(mv), .motor_term_sel_pin(ms), .run_pin(runp), .reverse_pin(revp));
  frc_top #(.DWELL_STEP_CYC(STEP)) u_frc_top (.clk(clk), .rstn(rstn), .avs_address(adr),
    .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(4'hF),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .max_freq(16'h1388),
    .main_freq_x(16'h0BB8), .aux_raw_y(yraw), .aux_is_digital(aux_dig),
    .updown_adjust(16'h00C8), .source_freq_0(src[0]), .source_freq_1(src[1]),
    .source_freq_2(src[2]), .source_freq_3(src[3]), .source_freq_4(src[4]),
    .source_freq_5(src[5]), .source_freq_6(src[6]), .source_freq_7(src[7]),
    .source_freq_8(src[8]), .cmd_channel(cmd), .switch_term_pin(sw),
    .motor_term_valid_pin(mv), .motor_term_sel_pin(ms), .run_pin(runp),
    .reverse_pin(revp), .heatsink_temp(temp), .output_freq(ofreq),
    .freq_reference(fref), .motor_set_two(m2), .fan_on(fan), .zero_hold(zh),
    .dir_reverse(drev), .load_speed(lspd), .load_speed_places(lpl), .monitor_places(mpl));
  task automatic results;
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // requests are held until waitrequest is seen low, then a free edge follows
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    wdat <= d;
    wr_en <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    adr <= a;
    rd_en <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    chk(rdat, exp);
    rd_en <= 1'b0;
    @(posedge clk);
  endtask
  // pins need sync stages and the scaler a pipeline before outputs settle
  task automatic settle;
    repeat (10) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    for (int i = 0; i < 9; i++) src[i] = 16'(100 * (i + 1));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rc(FRC_OFS_DISP_A, 32'h401F);
    rc(FRC_OFS_DISP_B, 32'h401F);
    rc(FRC_OFS_DISP_STOP, 32'h401F);
    rc(FRC_OFS_LOAD_FACTOR, 32'h7530);
    rc(FRC_OFS_DECIMALS, 32'h15);
    wr(FRC_OFS_LOAD_TYPE, 32'h2);
    rc(FRC_OFS_LOAD_TYPE, 32'h1);
    rc(8'hFC, 32'h0);
    wr(FRC_OFS_AUX_RANGE, 32'h64);
    wr(FRC_OFS_OFFSET_FREQ, 32'h32);
    for (int i = 0; i < 12; i++) begin
      wr(FRC_OFS_COMB_MODE, {24'h0, TAB[i][47:40]});
      term[0] <= TAB[i][32];
      yraw <= TAB[i][31:16];
      settle();
      chk(fref, TAB[i][15:0]);
    end
    wr(FRC_OFS_COMB_MODE, 32'h01);
    wr(FRC_OFS_COMB_MODE, 32'h05);
    rc(FRC_OFS_COMB_MODE, 32'h01);
    wr(FRC_OFS_AUX_RANGE, 32'h32);
    settle();
    chk(fref, 32'h0DDE);
    wr(FRC_OFS_AUX_RANGE, 32'h164);
    settle();
    chk(fref, 32'h0E42);
    wr(FRC_OFS_AUX_RANGE, 32'h64);
    aux_dig <= 1'b1;
    settle();
    chk(fref, 32'h0CB2);
    aux_dig <= 1'b0;
    cmd <= 2'h0;
    for (int c = 1; c < 10; c++) begin
      wr(FRC_OFS_BINDING, 32'(c));
      settle();
      chk(fref, {16'h0, src[c-1]});
    end
    wr(FRC_OFS_BINDING, 32'h950);
    settle();
    chk(fref, 32'h0FD2);
    for (int c = 1; c < 4; c++) begin
      cmd <= 2'(c);
      settle();
      chk(fref, c == 1 ? 32'h1F4 : c == 2 ? 32'h384 : 32'hFD2);
    end
    wr(FRC_OFS_FAN_MODE, 32'h0);
    temp <= 16'h0029;
    settle();
    chk(fan, 1);
    temp <= 16'h0028;
    settle();
    chk(fan, 0);
    term[3] <= 1'b1;
    settle();
    chk(fan, 1);
    term[3] <= 1'b0;
    wr(FRC_OFS_FAN_MODE, 32'h1);
    settle();
    chk(fan, 1);
    wr(FRC_OFS_MOTOR_SEL, 32'h1);
    settle();
    chk(m2, 1);
    term[2:1] <= 2'b01;
    settle();
    chk(m2, 0);
    term[2:1] <= 2'b00;
    wr(FRC_OFS_COMB_MODE, 32'h00);
    wr(FRC_OFS_DWELL, 32'h2);
    term[4] <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (zh === 1'b1) n++;
    end
    chk(32'(n >= 2 * STEP && n <= 2 * STEP + 2), 1);
    chk(drev, 1);
    chk(fref, 32'h0BB8);
    wr(FRC_OFS_LOAD_FACTOR, 32'h4E20);
    term[3] <= 1'b1;
    settle();
    chk(lspd, 32'h1F40);
    term[3] <= 1'b0;
    settle();
    chk(lspd, 32'h1770);
    wr(FRC_OFS_DECIMALS, 32'h12);
    wr(FRC_OFS_DECIMALS, 32'h34);
    settle();
    chk({lpl, mpl}, 32'h9);
    rc(FRC_OFS_DECIMALS, 32'h12);
    results();
  end
endmodule
`default_nettype wire
